/* core/tx_fmt_cfg.svh */
/*
 Offsets, field reset values and fixed figures of the transmit input
 formatter, gain and adaptive gain block.
 Assumes APB with 32-bit data; byte address is four times the index.
*/
`ifndef TX_FMT_CFG_SVH
`define TX_FMT_CFG_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_INPUT_MODE 6'h10
`define IDX_STROBE_TIMING 6'h11
`define IDX_STROBE_COUNTER 6'h12
`define IDX_GAIN_LOW 6'h13
`define IDX_GAIN_HIGH_CTRL 6'h14
`define IDX_LOWER_LIMIT 6'h15
`define IDX_UPPER_LIMIT 6'h16
`define IDX_RUNS_THRESH 6'h17
`define IDX_LOOP_SHIFTS 6'h18
`define IDX_GAIN_READBACK 6'h19

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INPUT_MODE 16'h0000
`define RST_STROBE_TIMING 16'h0000
`define RST_STROBE_COUNTER 16'h0000
`define RST_GAIN_LOW 16'h1000
`define RST_GAIN_HIGH_CTRL 16'h0008
`define RST_ZERO 16'h0000

// ----------------------------------------------------------------
// Codes and figures
// ----------------------------------------------------------------
`define SRC_TEST 3'h0
`define SRC_TDM_B_TO_D 3'h1
`define SRC_NORMAL 3'h2
`define SRC_TDM_A 3'h6
`define FSO_QUIET 2'h0
`define FSO_XMT 2'h1
`define FSO_RCV 2'h2
`define BITS_MAX 3'h5
`define GAIN_FRAC 12
`define LIM_FULL 37'sh0_0007_FFFF
`define LIM_HALF 37'sh0_0003_FFFF
`define GAIN_MAX 20'h7_FFFF

`endif

/* core/tx_fmt_pkg.sv */
/*
 Field layouts of the block's registers and its output carrier.
 Assumes tx_fmt_cfg.svh supplies the numeric constants.
*/
package tx_fmt_pkg;
    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] fso_sel;
        logic xmt;
        logic [2:0] src;
        logic pariq;
        logic iqmux;
        logic [2:0] pins;
        logic [2:0] bits;
    } input_mode_t;

    typedef struct packed {
        logic rsvd;
        logic [2:0] fso_dly;
        logic [3:0] sck_div;
        logic [3:0] load_second;
        logic [3:0] load_first;
    } strobe_timing_t;

    typedef struct packed {
        logic [3:0] nfs;
        logic [11:0] strobe_spacing;
    } strobe_counter_t;

    typedef struct packed {
        logic [3:0] zmag;
        logic gain_out;
        logic hold;
        logic half;
        logic [4:0] rnd;
        logic freeze;
        logic [2:0] gain_high;
    } gain_ctrl_t;

    typedef struct packed {
        logic [7:0] thresh;
        logic [3:0] sat_cnt;
        logic [3:0] zero_cnt;
    } runs_t;

    typedef struct packed {
        logic [3:0] sat;
        logic [3:0] zro;
        logic [3:0] abv;
        logic [3:0] blw;
    } shifts_t;

    typedef struct packed {
        logic valid;
        logic [19:0] i;
        logic [19:0] q;
    } lane_out_t;
endpackage

/* core/tx_input_format_gain_agc.sv */
/*
 Transmit input formatter with channel clock divider, frame strobe
 generation, gain with rounding and saturation, and adaptive gain loop.
 Assumes an APB master on sys_clk and sample pins from unrelated logic.
*/
`include "tx_fmt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tx_input_format_gain_agc #(
    parameter int IS_CHANNEL_A = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] tx_pins,
    input wire logic [15:0] tdm_data,
    input wire logic rx_strobe_in,
    output tx_fmt_pkg::lane_out_t out_data,
    output logic chan_clk,
    output logic frame_strobe,
    output logic fir_swap,
    output logic tx_mode
);
    import tx_fmt_pkg::*;

    if (IS_CHANNEL_A != 0 && IS_CHANNEL_A != 1) begin : g_check
        $error("IS_CHANNEL_A must be 0 or 1");
    end

    // ----------------------------------------------------------------
    // Register file over APB
    // ----------------------------------------------------------------
    input_mode_t mode_q;
    strobe_timing_t timing_q;
    strobe_counter_t counter_q;
    gain_ctrl_t gctrl_q;
    runs_t runs_q;
    shifts_t shifts_q;
    logic [15:0] gain_low_q;
    logic [15:0] lower_q;
    logic [15:0] upper_q;
    logic [15:0] readback_q;
    logic [18:0] agc_gain_q;
    logic [5:0] idx;
    logic mapped;
    logic wr_en;
    logic [15:0] rd_val;

    assign idx = paddr[7:2];
    assign wr_en = psel && penable && pready && pwrite && mapped;

    always_comb begin
        mapped = (paddr[1:0] == 2'h0);
        rd_val = 16'h0000;
        unique case (idx)
            `IDX_INPUT_MODE: rd_val = {2'h0, mode_q[13:0]};
            `IDX_STROBE_TIMING: rd_val = {1'b0, timing_q[14:0]};
            `IDX_STROBE_COUNTER: rd_val = counter_q;
            `IDX_GAIN_LOW: rd_val = gain_low_q;
            `IDX_GAIN_HIGH_CTRL: rd_val = gctrl_q;
            `IDX_LOWER_LIMIT: rd_val = lower_q;
            `IDX_UPPER_LIMIT: rd_val = upper_q;
            `IDX_RUNS_THRESH: rd_val = runs_q;
            `IDX_LOOP_SHIFTS: rd_val = shifts_q;
            `IDX_GAIN_READBACK: rd_val = readback_q;
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle after setup, so the access phase never waits
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && mapped) ? {16'h0000, rd_val} : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode_q <= `RST_INPUT_MODE;
            timing_q <= `RST_STROBE_TIMING;
            counter_q <= `RST_STROBE_COUNTER;
            gain_low_q <= `RST_GAIN_LOW;
            gctrl_q <= `RST_GAIN_HIGH_CTRL;
            lower_q <= `RST_ZERO;
            upper_q <= `RST_ZERO;
            runs_q <= `RST_ZERO;
            shifts_q <= `RST_ZERO;
        end else if (wr_en) begin
            unique case (idx)
                `IDX_INPUT_MODE: mode_q <= pwdata[15:0];
                `IDX_STROBE_TIMING: timing_q <= pwdata[15:0];
                `IDX_STROBE_COUNTER: counter_q <= pwdata[15:0];
                `IDX_GAIN_LOW: gain_low_q <= pwdata[15:0];
                `IDX_GAIN_HIGH_CTRL: gctrl_q <= pwdata[15:0];
                `IDX_LOWER_LIMIT: lower_q <= pwdata[15:0];
                `IDX_UPPER_LIMIT: upper_q <= pwdata[15:0];
                `IDX_RUNS_THRESH: runs_q <= pwdata[15:0];
                `IDX_LOOP_SHIFTS: shifts_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [15:0] pins_meta_q;
    logic [15:0] pins_sync_q;
    logic rxs_meta_q;
    logic rxs_sync_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pins_meta_q <= 16'h0000;
            pins_sync_q <= 16'h0000;
            rxs_meta_q <= 1'b0;
            rxs_sync_q <= 1'b0;
        end else begin
            pins_meta_q <= tx_pins;
            pins_sync_q <= pins_meta_q;
            rxs_meta_q <= rx_strobe_in;
            rxs_sync_q <= rxs_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Channel clock divider and frame strobe
    // ----------------------------------------------------------------
    logic [3:0] div_cnt_q;
    logic tick;
    logic [11:0] fs_cnt_q;
    logic tx_fs;
    logic [6:0] fso_pipe_q;
    logic [3:0] nfs_cnt_q;
    logic [2:0] dly_idx;

    assign tick = (div_cnt_q >= timing_q.sck_div);
    // Strobe every spacing ticks; a spacing of zero behaves as one
    assign tx_fs = tick && ({1'b0, fs_cnt_q} + 13'h0001 >= {1'b0, counter_q.strobe_spacing}) && mode_q.xmt;
    assign dly_idx = (timing_q.fso_dly == 3'h0) ? 3'h0 : timing_q.fso_dly - 3'h1;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            div_cnt_q <= 4'h0;
            chan_clk <= 1'b0;
        end else begin
            div_cnt_q <= tick ? 4'h0 : div_cnt_q + 4'h1;
            // At a divider of zero the channel clock cannot toggle and stays high
            chan_clk <= (tick ? 4'h0 : div_cnt_q + 4'h1) <= {1'b0, timing_q.sck_div[3:1]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fs_cnt_q <= 12'h000;
        end else if (tick && mode_q.xmt) begin
            fs_cnt_q <= tx_fs ? 12'h000 : fs_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fso_pipe_q <= 7'h00;
        end else if (tick) begin
            fso_pipe_q <= {fso_pipe_q[5:0], tx_fs};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            frame_strobe <= 1'b0;
        end else begin
            unique case (mode_q.fso_sel)
                `FSO_XMT: frame_strobe <= fso_pipe_q[dly_idx];
                `FSO_RCV: frame_strobe <= rxs_sync_q;
                default: frame_strobe <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            nfs_cnt_q <= 4'h0;
            fir_swap <= 1'b0;
        end else if (tx_fs) begin
            if (nfs_cnt_q + 4'h1 >= counter_q.nfs) begin
                nfs_cnt_q <= 4'h0;
                fir_swap <= !fir_swap;
            end else begin
                nfs_cnt_q <= nfs_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_mode <= 1'b0;
        end else begin
            tx_mode <= mode_q.xmt;
        end
    end

    // ----------------------------------------------------------------
    // Input word assembly
    // ----------------------------------------------------------------
    logic [15:0] src_data;
    logic [15:0] test_q;
    logic [2:0] tdm_code;
    logic fmt_on;
    logic [19:0] word_q;
    logic [19:0] word_d;
    logic [2:0] nib_q;
    logic [3:0] nib_d;
    logic word_done;
    logic [19:0] word_just;

    assign tdm_code = (IS_CHANNEL_A == 1) ? `SRC_TDM_A : `SRC_TDM_B_TO_D;
    // Illegal word and pin codes are served as quiet
    assign fmt_on = mode_q.xmt && (mode_q.bits != 3'h0) && (mode_q.bits <= `BITS_MAX)
        && (mode_q.pins == 3'h1 || mode_q.pins == 3'h2 || mode_q.pins == 3'h4);

    always_comb begin
        if (mode_q.src == `SRC_NORMAL) begin
            src_data = pins_sync_q;
        end else if (mode_q.src == tdm_code) begin
            src_data = tdm_data;
        end else if (mode_q.src == `SRC_TEST) begin
            src_data = test_q;
        end else begin
            src_data = 16'h0000;
        end
    end

    always_comb begin
        word_d = word_q;
        unique case (mode_q.pins)
            3'h1: word_d = {word_q[15:0], src_data[15:12]};
            3'h2: word_d = {word_q[11:0], src_data[15:8]};
            3'h4: word_d = {word_q[3:0], src_data};
            default: word_d = word_q;
        endcase
        // One spare bit: four nibbles on top of four would wrap
        nib_d = {1'b0, nib_q} + {1'b0, mode_q.pins};
        word_done = fmt_on && tick && (nib_d >= {1'b0, mode_q.bits});
        word_just = word_d << (3'(`BITS_MAX - mode_q.bits) * 4);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            word_q <= 20'h0_0000;
            nib_q <= 3'h0;
            test_q <= 16'h0000;
        end else begin
            if (tick) begin
                test_q <= test_q + 16'h0001;
            end
            // A frame strobe realigns the word boundary
            if (!fmt_on || tx_fs) begin
                nib_q <= 3'h0;
            end else if (tick) begin
                word_q <= word_d;
                nib_q <= word_done ? 3'h0 : nib_d[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // I/Q packing
    // ----------------------------------------------------------------
    logic [15:0] i_hold_q;
    logic q_phase_q;
    logic pair_valid;
    logic [15:0] pair_i;
    logic [15:0] pair_q;
    logic [15:0] w16;

    assign w16 = word_just[19:4];

    always_comb begin
        pair_valid = 1'b0;
        pair_i = w16;
        pair_q = 16'h0000;
        if (word_done) begin
            if (mode_q.pariq) begin
                pair_valid = 1'b1;
                pair_i = {w16[15:8], 8'h00};
                pair_q = {w16[7:0], 8'h00};
            end else if (mode_q.iqmux) begin
                pair_valid = q_phase_q;
                pair_i = i_hold_q;
                pair_q = w16;
            end else begin
                pair_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            i_hold_q <= 16'h0000;
            q_phase_q <= 1'b0;
        end else if (!mode_q.iqmux || mode_q.pariq || tx_fs) begin
            q_phase_q <= 1'b0;
        end else if (word_done) begin
            q_phase_q <= !q_phase_q;
            if (!q_phase_q) begin
                i_hold_q <= w16;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gain, rounding and saturation
    // ----------------------------------------------------------------
    function automatic logic [20:0] apply_gain(input logic [15:0] s, input logic [18:0] g,
                                               input logic [4:0] rnd, input logic half);
        logic signed [35:0] p;
        logic signed [36:0] r;
        logic signed [36:0] lim;
        logic sat;
        logic [19:0] mask;
        p = $signed(s) * $signed({1'b0, g});
        r = {p[35], p};
        r = r >>> `GAIN_FRAC;
        if (rnd != 5'h00) begin
            r = r + (37'sd1 <<< (rnd - 5'h01));
        end
        lim = half ? `LIM_HALF : `LIM_FULL;
        sat = 1'b0;
        if (r > lim) begin
            r = lim;
            sat = 1'b1;
        end else if (r < -lim - 37'sd1) begin
            r = -lim - 37'sd1;
            sat = 1'b1;
        end
        mask = 20'hF_FFFF << rnd;
        return {sat, r[19:0] & mask};
    endfunction

    logic [18:0] manual_gain;
    logic [18:0] use_gain;
    logic [20:0] res_i;
    logic [20:0] res_q;

    assign manual_gain = {gctrl_q.gain_high, gain_low_q};
    assign use_gain = gctrl_q.freeze ? manual_gain : agc_gain_q;
    assign res_i = apply_gain(pair_i, use_gain, gctrl_q.rnd, gctrl_q.half);
    assign res_q = apply_gain(pair_q, use_gain, gctrl_q.rnd, gctrl_q.half);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            out_data <= '0;
        end else begin
            out_data.valid <= pair_valid;
            if (pair_valid) begin
                out_data.i <= res_i[19:0];
                out_data.q <= res_q[19:0];
                if (gctrl_q.gain_out) begin
                    out_data.i[7:0] <= use_gain[18:11];
                    out_data.q[7:0] <= use_gain[18:11];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Adaptive gain loop
    // ----------------------------------------------------------------
    logic [15:0] mag;
    logic is_zero;
    logic is_sat;
    logic [3:0] zero_run_q;
    logic [3:0] sat_run_q;
    logic [19:0] g20;
    logic [19:0] lo_lim;
    logic [19:0] hi_lim;
    logic [19:0] next_g;

    function automatic logic [19:0] step(input logic [19:0] g, input logic [3:0] sh);
        return (sh == 4'h0) ? 20'h0_0000 : (g >> sh);
    endfunction

    always_comb begin
        mag = res_i[19] ? 16'(~res_i[19:4]) : res_i[19:4];
        is_zero = (mag[15:4] == 12'h000) && ((mag[3:0] & gctrl_q.zmag) == 4'h0);
        is_sat = res_i[20] || res_q[20];
        g20 = {1'b0, agc_gain_q};
        lo_lim = ({1'b0, manual_gain} > {4'h0, lower_q}) ? {1'b0, manual_gain} - {4'h0, lower_q} : 20'h0_0000;
        hi_lim = {1'b0, manual_gain} + {4'h0, upper_q};
        if (hi_lim > `GAIN_MAX) begin
            hi_lim = `GAIN_MAX;
        end
        if (is_sat && sat_run_q >= runs_q.sat_cnt) begin
            next_g = g20 - step(g20, shifts_q.sat);
        end else if (is_zero && zero_run_q >= runs_q.zero_cnt) begin
            next_g = g20 + step(g20, shifts_q.zro);
        end else if (mag[15:8] > runs_q.thresh) begin
            next_g = g20 - step(g20, shifts_q.abv);
        end else begin
            next_g = g20 + step(g20, shifts_q.blw);
        end
        if (next_g < lo_lim) begin
            next_g = lo_lim;
        end
        if (next_g > hi_lim) begin
            next_g = hi_lim;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            zero_run_q <= 4'h0;
            sat_run_q <= 4'h0;
        end else if (pair_valid) begin
            zero_run_q <= !is_zero ? 4'h0 : (zero_run_q == 4'hF) ? zero_run_q : zero_run_q + 4'h1;
            sat_run_q <= !is_sat ? 4'h0 : (sat_run_q == 4'hF) ? sat_run_q : sat_run_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            agc_gain_q <= {3'(`RST_GAIN_HIGH_CTRL), `RST_GAIN_LOW};
        end else if (gctrl_q.freeze) begin
            agc_gain_q <= manual_gain;
        end else if (pair_valid) begin
            agc_gain_q <= next_g[18:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            readback_q <= 16'h0000;
        end else if (!gctrl_q.hold) begin
            readback_q <= agc_gain_q[18:3];
        end
    end

endmodule

`default_nettype wire

/* verification/tx_fmt_sva.sv */
/*
 Checker for the transmit formatter and gain block.
 Assumes APB byte addresses of four times the register index.
*/
`timescale 1ns/1ns
`default_nettype none
module tx_fmt_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tx_fmt_pkg::lane_out_t out_data,
    input wire logic chan_clk,
    input wire logic frame_strobe,
    input wire logic tx_mode
);
    import tx_fmt_pkg::*;
    logic wr;
    logic [15:0] mode_q, tim_q, gctl_q, glo_q;
    // ----------------------------------------
    // Shadow copies of written settings
    // ----------------------------------------
    assign wr = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode_q <= 16'h0000;
            tim_q <= 16'h0000;
            gctl_q <= 16'h0008;
            glo_q <= 16'h1000;
        end else if (wr) begin
            if (paddr == 8'h40) mode_q <= pwdata[15:0];
            if (paddr == 8'h44) tim_q <= pwdata[15:0];
            if (paddr == 8'h4C) glo_q <= pwdata[15:0];
            if (paddr == 8'h50) gctl_q <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Mode must be steady: a sample in flight across a mode write is exempt
    real_q_zero_a: assert property (out_data.valid && $stable(mode_q) && mode_q[7:6] == 2'b00
        && !gctl_q[11] |-> out_data.q == 20'h0_0000) else $error("q lane not zero for real input");
    rx_no_sample_a: assert property ((!tx_mode)[*3] |-> !out_data.valid)
        else $error("sample produced in receive mode");
    strobe_quiet_a: assert property ((mode_q[13:12] == 2'h0)[*3] |-> !frame_strobe)
        else $error("frame strobe active while quiet");
    clk_undiv_a: assert property ((tim_q[11:8] == 4'h0)[*3] |-> chan_clk)
        else $error("channel clock not high at divider zero");
    round_clear_a: assert property (out_data.valid && !gctl_q[11] |->
        (out_data.i & ((20'h0_0001 << gctl_q[8:4]) - 20'h0_0001)) == 20'h0_0000) else $error("rounded bits not clear");
    half_sat_a: assert property (out_data.valid && gctl_q[9] |->
        $signed(out_data.i) < 20'sh4_0000 && $signed(out_data.i) >= -20'sh4_0000) else $error("half scale exceeded");
    gain_byte_a: assert property (out_data.valid && gctl_q[11] && gctl_q[3] |->
        out_data.i[7:0] == {gctl_q[2:0], glo_q[15:11]} && out_data.q[7:0] == out_data.i[7:0])
        else $error("gain byte wrong");
    readback_top_a: assert property (pready && !pwrite && paddr == 8'h64 && gctl_q[3] && !gctl_q[10] |->
        prdata == {16'h0000, gctl_q[2:0], glo_q[15:3]}) else $error("gain readback wrong");
endmodule
bind tx_input_format_gain_agc tx_fmt_sva i_sva (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .out_data, .chan_clk, .frame_strobe, .tx_mode);
`default_nettype wire

/* verification/tx_pins_model.sv */
/*
 Customer logic that drives the transmit sample pins.
 Assumes the bench supplies the word; pins are synced inside the block.
*/
`timescale 1ns/1ns
`default_nettype none
module tx_pins_model (
    input wire logic sys_clk,
    input wire logic drive_en,
    input wire logic [15:0] word,
    output logic [15:0] tx_pins
);
    // Released pins toggle so a stale value never passes for data
    always_ff @(posedge sys_clk) begin
        tx_pins <= drive_en ? word : ~tx_pins;
    end
endmodule
`default_nettype wire

/* verification/tx_input_format_gain_agc_tb_top.sv */
/*
 Self-checking bench: table of gain cases, then I/Q, quiet, strobe
 and adaptive gain cases. Assumes 100 MHz sys_clk and zero-wait APB.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module tx_input_format_gain_agc_tb_top;
    import tx_fmt_pkg::*;
    typedef struct packed { logic [15:0] lo, ctl, w; logic [19:0] i; } row_t;
    logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, drive_en, er, rxs;
    logic chan_clk, frame_strobe, fir_swap, tx_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] word, tx_pins, tdm;
    lane_out_t out_data;
    int err_count, total_checks, n, p;
    logic [15:0] quiet_modes [3] = '{16'h0A20, 16'h0A1C, 16'h0224};
    row_t rows [8] = '{
        '{16'h1000, 16'h0008, 16'h0123, 20'h0_0123},
        '{16'h1000, 16'h0008, 16'h8000, 20'hF_8000},
        '{16'h2000, 16'h0008, 16'h0123, 20'h0_0246},
        '{16'h1000, 16'h0048, 16'h0123, 20'h0_0120},
        '{16'h2000, 16'h0108, 16'h7000, 20'h1_0000},
        '{16'hFFFF, 16'h000F, 16'h7FFF, 20'h7_FFFF},
        '{16'hFFFF, 16'h020F, 16'h7FFF, 20'h3_FFFF},
        '{16'h1000, 16'h0808, 16'h0123, 20'h0_0102}};
    tx_input_format_gain_agc i_dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_pins, .tdm_data(tdm), .rx_strobe_in(rxs), .out_data, .chan_clk, .frame_strobe,
        .fir_swap, .tx_mode);
    tx_pins_model i_pins (.sys_clk, .drive_en, .word, .tx_pins);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_valid(input int k);
        p = 0;
        for (n = 0; n < 400 && p < k; n++) @(posedge sys_clk) if (out_data.valid === 1'b1) p++;
        if (p < k) begin
            err_count++;
            end_of_test();
        end
    endtask
    // Cycles between the second and third rising edge
    task automatic period(input int s);
        logic prev, cur;
        int e, t;
        prev = 1'b1;
        e = 0;
        t = 0;
        for (n = 0; n < 400 && e < 3; n++) begin
            @(posedge sys_clk);
            cur = (s == 2) ? fir_swap : (s == 1) ? frame_strobe : chan_clk;
            if (cur === 1'b1 && prev === 1'b0) begin
                e++;
                p = n - t;
                t = n;
            end
            prev = cur;
        end
        if (e < 3) begin
            err_count++;
            end_of_test();
        end
    endtask
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        drive_en = 1'b1;
        word = 16'h0000;
        tdm = 16'h0000;
        rxs = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(0, 8'h50, 16'h0000);
        `CHK(rd, 32'h0000_0008)
        apb(0, 8'h54, 16'h0000);
        `CHK(rd, 32'h0000_0000)
        apb(0, 8'h64, 16'h0000);
        `CHK(rd, 32'h0000_0200)
        apb(0, 8'hFC, 16'h0000);
        `CHK(er, 1'b1)
        foreach (rows[r]) begin
            apb(1, 8'h40, 16'h0000);
            apb(1, 8'h4C, rows[r].lo);
            apb(1, 8'h50, rows[r].ctl);
            word <= rows[r].w;
            apb(1, 8'h40, 16'h0A24);
            wait_valid(4);
            `CHK(out_data.i, rows[r].i)
            `CHK(out_data.q, rows[r].ctl[11] ? 20'h0_0002 : 20'h0_0000)
        end
        // Spacing zero strobes every tick, which would restart each I/Q pair
        apb(1, 8'h48, 16'h100A);
        apb(1, 8'h40, 16'h0000);
        apb(1, 8'h50, 16'h0008);
        word <= 16'h12F0;
        apb(1, 8'h40, 16'h0A64);
        wait_valid(4);
        `CHK({out_data.i, out_data.q}, {20'h0_12F0, 20'h0_12F0})
        apb(1, 8'h40, 16'h0AA4);
        wait_valid(4);
        `CHK({out_data.i, out_data.q}, {20'h0_1200, 20'hF_F000})
        tdm <= 16'h0321;
        apb(1, 8'h40, 16'h0E24);
        wait_valid(4);
        `CHK(out_data.i, 20'h0_0321)
        // Codes 6 and 7 of the word size are never written
        foreach (quiet_modes[k]) begin
            apb(1, 8'h40, 16'h0000);
            apb(1, 8'h40, quiet_modes[k]);
            p = 0;
            repeat (60) @(posedge sys_clk) if (out_data.valid === 1'b1) p++;
            `CHK(p, 0)
        end
        apb(1, 8'h44, 16'h1300);
        apb(1, 8'h40, 16'h1A24);
        period(0);
        `CHK(p, 4)
        period(1);
        `CHK(p, 40)
        period(2);
        `CHK(p, 80)
        apb(1, 8'h40, 16'h2A24);
        rxs <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(frame_strobe, 1'b1)
        rxs <= 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHK(frame_strobe, 1'b0)
        apb(1, 8'h40, 16'h0A24);
        word <= 16'h0010;
        apb(1, 8'h5C, 16'h00FF);
        apb(1, 8'h60, 16'h0011);
        apb(1, 8'h58, 16'h0100);
        apb(1, 8'h50, 16'h0000);
        wait_valid(60);
        apb(0, 8'h64, 16'h0000);
        `CHK(rd, 32'h0000_0220)
        word <= 16'h4000;
        apb(1, 8'h58, 16'h0000);
        apb(1, 8'h54, 16'h0100);
        wait_valid(60);
        apb(0, 8'h64, 16'h0000);
        `CHK(rd, 32'h0000_01E0)
        end_of_test();
    end
endmodule
`default_nettype wire
